// ==== design/aprr_pkg.sv ====
//==============================================================================
// How it works
// - right input volume bit 15 switches the right input amplifier on, reset 0.
// - right input volume bit 14 silences the right amplifier and cuts it from the record mixer, reset 0.
// - with bit 13 clear a released gain applies at once, with it set at the first zero crossing after.
// - written input gains wait until a 1 is written to bit 8 of either input register, which releases both.
// - bits 7:2 are the 6-bit input gain, -12 dB at code 0 in 0.75 dB steps, resetting to 0 dB (code 16).
// - left output mixer control bit 15 switches the left output mixer on, reset 0.
// - left output mixer bit 12 adds the right converter and bit 11 the left one; bit 11 resets to 1.
// - left output mixer bits 2, 1, 0 add the left aux, right amp and left amp inputs, reset 0.
// - right output mixer control bit 15 switches the right output mixer on, reset 0.
// - right output mixer bit 12 adds the right converter and bit 11 the left one; bit 12 resets to 1.
// - right output mixer bits 3, 1, 0 add the right aux, right amp and left amp inputs, reset 0.
// - line out A control bit 15 enables that output and bit 11 routes the left converter, reset 0.
// - line out A bits 8, 3, 0 route the left input mixer, line out B and left output mixer, reset 0.
// - the left input volume register has the same layout and behaviour as the right one.
package aprr_pkg;

    //==========================================================================
    // register addresses
    localparam logic [7:0] ADDR_LEFT_IN = 8'h50;
    localparam logic [7:0] ADDR_RIGHT_IN = 8'h51;
    localparam logic [7:0] ADDR_LEFT_MIX = 8'h58;
    localparam logic [7:0] ADDR_RIGHT_MIX = 8'h59;
    localparam logic [7:0] ADDR_LINE_A = 8'h5c;

    //==========================================================================
    // input volume field positions
    localparam int BIT_AMP_ON = 15;
    localparam int BIT_AMP_SILENCE = 14;
    localparam int BIT_AMP_ZC = 13;
    localparam int BIT_GAIN_STROBE = 8;
    localparam int GAIN_LSB = 2;
    localparam int GAIN_W = 6;
    localparam logic [5:0] GAIN_RESET = 6'h10;

    //==========================================================================
    // mixer field positions
    localparam int BIT_MIX_ON = 15;
    localparam int BIT_RIGHT_CONV = 12;
    localparam int BIT_LEFT_CONV = 11;
    localparam int BIT_LEFT_AUX = 2;
    localparam int BIT_RIGHT_AUX = 3;
    localparam int BIT_RIGHT_AMP = 1;
    localparam int BIT_LEFT_AMP = 0;
    localparam int BIT_LINE_A_ON = 15;
    localparam int BIT_LINE_A_LCONV = 11;
    localparam int BIT_LINE_A_IN_MIX = 8;
    localparam int BIT_LINE_A_OUT_B = 3;
    localparam int BIT_LINE_A_OUT_MIX = 0;

    //==========================================================================
    // reset values and writable masks
    localparam logic [15:0] IN_RESET = 16'h0040;
    localparam logic [15:0] LEFT_MIX_RESET = 16'h0800;
    localparam logic [15:0] RIGHT_MIX_RESET = 16'h1000;
    localparam logic [15:0] LINE_A_RESET = 16'h0000;
    localparam logic [15:0] IN_MASK = 16'he0fc;
    localparam logic [15:0] LEFT_MIX_MASK = 16'h9807;
    localparam logic [15:0] RIGHT_MIX_MASK = 16'h980b;
    localparam logic [15:0] LINE_A_MASK = 16'h8909;

    //==========================================================================
    // carriers to the analogue path
    typedef struct packed {
        logic on;
        logic silence;
        logic [5:0] gain;
    } aprr_amp_s;

    typedef struct packed {
        logic on;
        logic right_conv;
        logic left_conv;
        logic aux;
        logic right_amp;
        logic left_amp;
    } aprr_out_mix_s;

    typedef struct packed {
        logic on;
        logic left_conv;
        logic left_in_mix;
        logic line_out_b;
        logic left_out_mix;
    } aprr_line_a_s;

endpackage : aprr_pkg

// ==== design/aprr_regs.sv ====
`timescale 1ns/1ps
module aprr_regs (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // control interface register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // zero-cross comparator pins, index 0 left, 1 right
    input wire logic [1:0] zero_cross_i,
    // analogue path controls
    output aprr_pkg::aprr_amp_s left_amp_o,
    output aprr_pkg::aprr_amp_s right_amp_o,
    output aprr_pkg::aprr_out_mix_s left_out_mix_o,
    output aprr_pkg::aprr_out_mix_s right_out_mix_o,
    output aprr_pkg::aprr_line_a_s line_out_a_o
);

    //==========================================================================
    // address decode
    function automatic logic is_in_addr(input logic [7:0] a);
        is_in_addr = (a == aprr_pkg::ADDR_LEFT_IN) || (a == aprr_pkg::ADDR_RIGHT_IN);
    endfunction : is_in_addr

    // index 0 left input volume, 1 right input volume
    logic [15:0] in_reg_r [2];
    logic [15:0] in_reg_nxt [2];
    logic [15:0] left_mix_r;
    logic [15:0] left_mix_nxt;
    logic [15:0] right_mix_r;
    logic [15:0] right_mix_nxt;
    logic [15:0] line_a_r;
    logic [15:0] line_a_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    // gain staging: released by the strobe, then applied to the amplifier
    logic [5:0] rel_gain_r [2];
    logic [5:0] rel_gain_nxt [2];
    logic [5:0] app_gain_r [2];
    logic [5:0] app_gain_nxt [2];
    logic [1:0] zc_wait_r;
    logic [1:0] zc_wait_nxt;

    // zero-cross synchroniser and edge stage
    logic [1:0] zc_meta_r;
    logic [1:0] zc_sync_r;
    logic [1:0] zc_prev_r;
    logic [1:0] zc_cross;
    logic gain_strobe;

    //==========================================================================
    // zero-cross pins pass two flops, a third flop gives the crossing edge
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            zc_meta_r <= 2'h0;
            zc_sync_r <= 2'h0;
            zc_prev_r <= 2'h0;
        end else begin
            zc_meta_r <= zero_cross_i;
            zc_sync_r <= zc_meta_r;
            zc_prev_r <= zc_sync_r;
        end
    end

    // either polarity change of the comparator is a crossing
    assign zc_cross = zc_sync_r ^ zc_prev_r;

    // a 1 on the strobe bit of either input register releases both gains
    assign gain_strobe = reg_wr_i && is_in_addr(reg_addr_i) && reg_wdata_i[aprr_pkg::BIT_GAIN_STROBE];

    //==========================================================================
    // register writes, undefined bits and the strobe bit never stored
    always_comb begin
        in_reg_nxt[0] = in_reg_r[0];
        in_reg_nxt[1] = in_reg_r[1];
        left_mix_nxt = left_mix_r;
        right_mix_nxt = right_mix_r;
        line_a_nxt = line_a_r;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                aprr_pkg::ADDR_LEFT_IN: begin
                    in_reg_nxt[0] = reg_wdata_i & aprr_pkg::IN_MASK;
                end
                aprr_pkg::ADDR_RIGHT_IN: begin
                    in_reg_nxt[1] = reg_wdata_i & aprr_pkg::IN_MASK;
                end
                aprr_pkg::ADDR_LEFT_MIX: begin
                    left_mix_nxt = reg_wdata_i & aprr_pkg::LEFT_MIX_MASK;
                end
                aprr_pkg::ADDR_RIGHT_MIX: begin
                    right_mix_nxt = reg_wdata_i & aprr_pkg::RIGHT_MIX_MASK;
                end
                aprr_pkg::ADDR_LINE_A: begin
                    line_a_nxt = reg_wdata_i & aprr_pkg::LINE_A_MASK;
                end
                default: begin
                    // unmapped addresses ignore writes
                end
            endcase
        end
    end

    //==========================================================================
    // gain staging per channel
    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            rel_gain_nxt[ch] = rel_gain_r[ch];
            app_gain_nxt[ch] = app_gain_r[ch];
            zc_wait_nxt[ch] = zc_wait_r[ch];
            if (gain_strobe) begin
                // release takes the field including this very write
                rel_gain_nxt[ch] = in_reg_nxt[ch][aprr_pkg::GAIN_LSB +: aprr_pkg::GAIN_W];
                if (in_reg_nxt[ch][aprr_pkg::BIT_AMP_ZC]) begin
                    zc_wait_nxt[ch] = 1'b1; // set wins over a same-cycle crossing
                end else begin
                    app_gain_nxt[ch] = rel_gain_nxt[ch];
                    zc_wait_nxt[ch] = 1'b0;
                end
            end else if (zc_wait_r[ch] && (zc_cross[ch] || !in_reg_r[ch][aprr_pkg::BIT_AMP_ZC])) begin
                // first crossing after release, or deferral switched off meanwhile
                app_gain_nxt[ch] = rel_gain_r[ch];
                zc_wait_nxt[ch] = 1'b0;
            end
        end
    end

    //==========================================================================
    // read data, one cycle after the read request
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                aprr_pkg::ADDR_LEFT_IN: rdata_nxt = in_reg_r[0];
                aprr_pkg::ADDR_RIGHT_IN: rdata_nxt = in_reg_r[1];
                aprr_pkg::ADDR_LEFT_MIX: rdata_nxt = left_mix_r;
                aprr_pkg::ADDR_RIGHT_MIX: rdata_nxt = right_mix_r;
                aprr_pkg::ADDR_LINE_A: rdata_nxt = line_a_r;
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    //==========================================================================
    // state registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_reg_r[0] <= aprr_pkg::IN_RESET;
            in_reg_r[1] <= aprr_pkg::IN_RESET;
            left_mix_r <= aprr_pkg::LEFT_MIX_RESET;
            right_mix_r <= aprr_pkg::RIGHT_MIX_RESET;
            line_a_r <= aprr_pkg::LINE_A_RESET;
            rdata_r <= 16'h0000;
            rel_gain_r[0] <= aprr_pkg::GAIN_RESET;
            rel_gain_r[1] <= aprr_pkg::GAIN_RESET;
            app_gain_r[0] <= aprr_pkg::GAIN_RESET;
            app_gain_r[1] <= aprr_pkg::GAIN_RESET;
            zc_wait_r <= 2'h0;
        end else begin
            in_reg_r[0] <= in_reg_nxt[0];
            in_reg_r[1] <= in_reg_nxt[1];
            left_mix_r <= left_mix_nxt;
            right_mix_r <= right_mix_nxt;
            line_a_r <= line_a_nxt;
            rdata_r <= rdata_nxt;
            rel_gain_r[0] <= rel_gain_nxt[0];
            rel_gain_r[1] <= rel_gain_nxt[1];
            app_gain_r[0] <= app_gain_nxt[0];
            app_gain_r[1] <= app_gain_nxt[1];
            zc_wait_r <= zc_wait_nxt;
        end
    end

    //==========================================================================
    // outputs, all straight from flip-flops
    assign reg_rdata_o = rdata_r;

    // amplifiers see the applied gain, never the pending one
    assign left_amp_o.on = in_reg_r[0][aprr_pkg::BIT_AMP_ON];
    assign left_amp_o.silence = in_reg_r[0][aprr_pkg::BIT_AMP_SILENCE];
    assign left_amp_o.gain = app_gain_r[0];
    assign right_amp_o.on = in_reg_r[1][aprr_pkg::BIT_AMP_ON];
    assign right_amp_o.silence = in_reg_r[1][aprr_pkg::BIT_AMP_SILENCE];
    assign right_amp_o.gain = app_gain_r[1];

    // left output mixer selects
    assign left_out_mix_o.on = left_mix_r[aprr_pkg::BIT_MIX_ON];
    assign left_out_mix_o.right_conv = left_mix_r[aprr_pkg::BIT_RIGHT_CONV];
    assign left_out_mix_o.left_conv = left_mix_r[aprr_pkg::BIT_LEFT_CONV];
    assign left_out_mix_o.aux = left_mix_r[aprr_pkg::BIT_LEFT_AUX];
    assign left_out_mix_o.right_amp = left_mix_r[aprr_pkg::BIT_RIGHT_AMP];
    assign left_out_mix_o.left_amp = left_mix_r[aprr_pkg::BIT_LEFT_AMP];

    // right output mixer selects
    assign right_out_mix_o.on = right_mix_r[aprr_pkg::BIT_MIX_ON];
    assign right_out_mix_o.right_conv = right_mix_r[aprr_pkg::BIT_RIGHT_CONV];
    assign right_out_mix_o.left_conv = right_mix_r[aprr_pkg::BIT_LEFT_CONV];
    assign right_out_mix_o.aux = right_mix_r[aprr_pkg::BIT_RIGHT_AUX];
    assign right_out_mix_o.right_amp = right_mix_r[aprr_pkg::BIT_RIGHT_AMP];
    assign right_out_mix_o.left_amp = right_mix_r[aprr_pkg::BIT_LEFT_AMP];

    // line out A routing
    assign line_out_a_o.on = line_a_r[aprr_pkg::BIT_LINE_A_ON];
    assign line_out_a_o.left_conv = line_a_r[aprr_pkg::BIT_LINE_A_LCONV];
    assign line_out_a_o.left_in_mix = line_a_r[aprr_pkg::BIT_LINE_A_IN_MIX];
    assign line_out_a_o.line_out_b = line_a_r[aprr_pkg::BIT_LINE_A_OUT_B];
    assign line_out_a_o.left_out_mix = line_a_r[aprr_pkg::BIT_LINE_A_OUT_MIX];

endmodule : aprr_regs

// ==== sim/aprr_regs_props.sv ====
`timescale 1ns/1ps
module aprr_regs_props (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    // comparator pins
    input wire logic [1:0] zero_cross_i,
    // analogue controls
    input wire aprr_pkg::aprr_amp_s left_amp_o,
    input wire aprr_pkg::aprr_amp_s right_amp_o,
    input wire aprr_pkg::aprr_out_mix_s left_out_mix_o,
    input wire aprr_pkg::aprr_out_mix_s right_out_mix_o,
    input wire aprr_pkg::aprr_line_a_s line_out_a_o
);
    logic [1:0] zc_prev_r;
    logic [2:0] quiet_r;
    // edges since the comparator pins last moved, so no crossing is in flight
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            zc_prev_r <= 2'h0;
            quiet_r <= 3'h0;
        end else begin
            zc_prev_r <= zero_cross_i;
            quiet_r <= (zero_cross_i != zc_prev_r) ? 3'h0 : ((quiet_r == 3'h7) ? quiet_r : quiet_r + 3'h1);
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_reset_vals: assert property (
        $fell(rst_i) |-> right_amp_o.gain == 6'h10 && left_out_mix_o.left_conv == 1'b1
        && right_out_mix_o.right_conv == 1'b1) else $error("reset defaults wrong");
    a_left_mix_wr: assert property (
        reg_wr_i && reg_addr_i == 8'h58 |=> left_out_mix_o == {$past(reg_wdata_i[15]),
        $past(reg_wdata_i[12:11]), $past(reg_wdata_i[2:0])}) else $error("left mixer not updated");
    a_right_mix_wr: assert property (
        reg_wr_i && reg_addr_i == 8'h59 |=> right_out_mix_o == {$past(reg_wdata_i[15]),
        $past(reg_wdata_i[12:11]), $past(reg_wdata_i[3]), $past(reg_wdata_i[1:0])}) else $error("right mixer bad");
    a_line_a_wr: assert property (
        reg_wr_i && reg_addr_i == 8'h5c |=> line_out_a_o == {$past(reg_wdata_i[15]), $past(reg_wdata_i[11]),
        $past(reg_wdata_i[8]), $past(reg_wdata_i[3]), $past(reg_wdata_i[0])}) else $error("line out bad");
    a_amp_ctrl: assert property (
        reg_wr_i && reg_addr_i == 8'h51 |=> right_amp_o.on == $past(reg_wdata_i[15])
        && right_amp_o.silence == $past(reg_wdata_i[14])) else $error("right amp enable or silence bad");
    a_gain_now: assert property (
        reg_wr_i && reg_addr_i == 8'h51 && reg_wdata_i[8] && !reg_wdata_i[13]
        |=> right_amp_o.gain == $past(reg_wdata_i[7:2])) else $error("gain not applied at once");
    a_gain_staged: assert property (
        reg_wr_i && reg_addr_i == 8'h50 && !reg_wdata_i[8] && quiet_r >= 3'h4 && !$past(reg_wr_i)
        |=> $stable(right_amp_o.gain)) else $error("gain moved without strobe");
    a_unmapped_rd: assert property (
        reg_rd_i && !(reg_addr_i inside {8'h50, 8'h51, 8'h58, 8'h59, 8'h5c})
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    a_in_rd_mask: assert property (
        reg_rd_i && reg_addr_i[7:1] == 7'h28 |=> (reg_rdata_o & 16'h1f03) == 16'h0000)
        else $error("undefined input bits read nonzero");
endmodule : aprr_regs_props
bind aprr_regs aprr_regs_props u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .zero_cross_i(zero_cross_i), .left_amp_o(left_amp_o), .right_amp_o(right_amp_o),
    .left_out_mix_o(left_out_mix_o), .right_out_mix_o(right_out_mix_o), .line_out_a_o(line_out_a_o));

// ==== sim/aprr_regs_tb_top.sv ====
`timescale 1ns/1ps
module aprr_regs_tb_top;
    logic sys_clk_i, rst_i, wr, rd;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, d;
    logic [1:0] zc;
    aprr_pkg::aprr_amp_s l_amp, r_amp;
    aprr_pkg::aprr_out_mix_s l_mix, r_mix;
    aprr_pkg::aprr_line_a_s line_a;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int idx;
    logic [15:0] sh [6];
    logic [5:0] apl [2];
    logic [7:0] at [6] = '{8'h50, 8'h51, 8'h58, 8'h59, 8'h5c, 8'h5d};
    logic [15:0] mk [6] = '{aprr_pkg::IN_MASK, aprr_pkg::IN_MASK, aprr_pkg::LEFT_MIX_MASK,
        aprr_pkg::RIGHT_MIX_MASK, aprr_pkg::LINE_A_MASK, 16'h0000};
    aprr_regs uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .zero_cross_i(zc), .left_amp_o(l_amp), .right_amp_o(r_amp),
        .left_out_mix_o(l_mix), .right_out_mix_o(r_mix), .line_out_a_o(line_a));
    // clock and hang guard
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc > 5000) begin
            error_cnt++;
            summarize();
        end
    end
    task summarize;
        if (error_cnt == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // expected control outputs from the shadow registers and applied gains
    function automatic logic [15:0] exp_out(int k);
        case (k)
            0, 1: return {8'h00, sh[k][15:14], apl[k]};
            2: return {10'h000, sh[2][15], sh[2][12:11], sh[2][2:0]};
            3: return {10'h000, sh[3][15], sh[3][12:11], sh[3][3], sh[3][1:0]};
            default: return {11'h000, sh[4][15], sh[4][11], sh[4][8], sh[4][3], sh[4][0]};
        endcase
    endfunction : exp_out
    task chk_outs;
        check("left_amp", 16'(l_amp), exp_out(0));
        check("right_amp", 16'(r_amp), exp_out(1));
        check("left_mix", 16'(l_mix), exp_out(2));
        check("right_mix", 16'(r_mix), exp_out(3));
        check("line_a", 16'(line_a), exp_out(4));
    endtask : chk_outs
    // one write cycle, then the shadow, and a strobe applies each gain whose bit 13 is clear
    task write_reg(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        for (int k = 0; k < 6; k++) if (at[k] == a) sh[k] = v & mk[k];
        if (a[7:1] == 7'h28 && v[8]) for (int k = 0; k < 2; k++) if (!sh[k][13]) apl[k] = sh[k][7:2];
        @(negedge sys_clk_i);
    endtask : write_reg
    task read_reg(input int i);
        @(posedge sys_clk_i);
        rd <= 1'b1;
        addr <= at[i];
        @(posedge sys_clk_i);
        rd <= 1'b0;
        @(posedge sys_clk_i);
        #1 check("readback", rdata, sh[i]);
    endtask : read_reg
    // move the comparator pins: the gain holds for two edges and lands on the third
    task move_zc(input logic [1:0] z, input int ch, input logic [5:0] g);
        @(posedge sys_clk_i);
        zc <= z;
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk_outs;
        @(posedge sys_clk_i);
        apl[ch] = g;
        @(negedge sys_clk_i);
        chk_outs;
    endtask : move_zc
    initial begin
        rst_i = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        zc = 2'b00;
        void'($urandom(32'h4b78));
        sh = '{16'h0040, 16'h0040, 16'h0800, 16'h1000, 16'h0000, 16'h0000};
        apl = '{6'h10, 6'h10};
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(negedge sys_clk_i);
        chk_outs;
        for (int i = 0; i < 6; i++) read_reg(i);
        // random writes with zero-cross kept clear, unmapped place included
        repeat (60) begin
            idx = $urandom_range(5);
            d = $urandom();
            if (idx < 2) d[13] = 1'b0;
            write_reg(at[idx], d);
            chk_outs;
            read_reg(idx);
        end
        // deferred gain waits for the right comparator to move
        write_reg(8'h51, 16'h2150);
        repeat (3) begin
            @(negedge sys_clk_i);
            chk_outs;
        end
        move_zc(2'b10, 1, 6'h14);
        // strobe on the left register releases both, each waits for its own crossing
        write_reg(8'h51, 16'h2008);
        chk_outs;
        write_reg(8'h50, 16'h21a4);
        chk_outs;
        move_zc(2'b11, 0, 6'h29);
        // deferral switched off while waiting applies the released gain one edge later
        write_reg(8'h51, 16'h0030);
        chk_outs;
        @(posedge sys_clk_i);
        apl[1] = 6'h02;
        @(negedge sys_clk_i);
        chk_outs;
        read_reg(1);
        summarize();
    end
endmodule : aprr_regs_tb_top
